// file: hdl/byte_spi_master.sv
// Purpose: byte-wide serial peripheral master with holding registers
// Assumes: host strobes are one-cycle pulses synchronous to CLK_SYS
// Notes: a small receive FIFO sits between shifter and receive register
`timescale 1ns/1ns
`include "spi_map.svh"

// ==========================================================
// receive FIFO
module byte_fifo #(
  parameter int WIDTH = `SPI_BYTE_BITS,
  parameter int DEPTH = `SPI_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_s;
  fifo_s q;
  fifo_s d;
  logic [AW:0] used;

  // pointers carry one extra bit so full and empty differ
  assign used = q.wp - q.rp;
  assign in_ready = (used != FULL_CNT);
  assign out_valid = (used != '0);
  assign out_data = q.mem[q.rp[AW-1:0]];

  // write and read ports
  always_comb begin
    d = q;
    if (in_valid && in_ready) begin
      d.mem[q.wp[AW-1:0]] = in_data;
      d.wp = q.wp + 1'h1;
    end
    if (out_valid && out_ready) begin
      d.rp = q.rp + 1'h1;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ==========================================================
// serial master core
module byte_spi_master #(
  parameter int FIFO_DEPTH = `SPI_FIFO_DEPTH
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic TX_WR,
  input wire logic [`SPI_BYTE_BITS-1:0] TX_WDATA,
  input wire logic RX_RD,
  input wire logic LSB_FIRST_SEL,
  input wire logic TX_EDGE_SEL,
  input wire logic RX_EDGE_SEL,
  input wire logic CLK_POL,
  input wire logic REF_CLOCK_SELECT,
  input wire logic [`SPI_PRE_W-1:0] PRELOAD,
  input wire logic [1:0] DIN_SELECT,
  input wire logic OUT_PIN_DRIVE_DIR,
  input wire logic CS_ASSERT,
  input wire logic SER_IN_PIN,
  input wire logic SER_OUT_PIN_I,
  output logic SER_OUT_PIN_O,
  output logic SER_OUT_PIN_OE,
  output logic SER_CLK_PIN,
  output logic CHIP_SEL_N_PIN,
  output logic [`SPI_BYTE_BITS-1:0] RX_BYTE_REG,
  output logic TX_HOLDING_EMPTY,
  output logic RX_HOLDING_FULL,
  output logic TX_EMPTY_IRQ_SRC,
  output logic RX_FULL_IRQ_SRC,
  output logic TX_DMA_REQUEST,
  output logic RX_DMA_REQUEST
);
  localparam logic [`SPI_REF2M_W-1:0] REF2M_DIV =
    `SPI_REF2M_W'(`SPI_SYS_HZ / `SPI_REF2M_HZ);
  localparam logic [2:0] TOP_BIT = 3'(`SPI_BYTE_BITS - 1);
  localparam spi_pkg::core_s CORE_RST = '{
    state: spi_pkg::ST_IDLE, cs_n: 1'h1, default: '0};

  spi_pkg::core_s q;
  spi_pkg::core_s d;
  logic tick2m;
  logic ref_tick;
  logic half_end;
  logic load;
  logic pop;
  logic rising;
  logic [`SPI_PRE_W-1:0] reload;
  logic [4:0] last_tog;
  logic [2:0] pos;
  logic [2:0] pos_even;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [`SPI_BYTE_BITS-1:0] fifo_out_data;

  // ==========================================================
  // receive FIFO; a full FIFO holds the sequencer in push
  byte_fifo #(
    .WIDTH(`SPI_BYTE_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(CLK_SYS),
    .rst(RST),
    .in_valid(q.state == spi_pkg::ST_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(q.rx_sh),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );

  // ==========================================================
  // next-state logic
  always_comb begin
    d = q;
    load = 1'h0;
    rising = 1'h0;
    // free-running 2MHz tick from the system clock
    tick2m = (q.pre2m == '0);
    d.pre2m = tick2m ? (REF2M_DIV - 1'h1) : (q.pre2m - 1'h1);
    // zero preload forces the fast reference
    ref_tick = (PRELOAD == '0) || !REF_CLOCK_SELECT || tick2m;
    reload = (PRELOAD == '0) ? '0 : (PRELOAD - 1'h1);
    half_end = ref_tick && (q.div == '0);
    last_tog = q.dual ? (`SPI_TOG_DUAL - 5'h1) : (`SPI_TOG_FULL - 5'h1);
    pos = LSB_FIRST_SEL ? q.rx_cnt : (TOP_BIT - q.rx_cnt);
    pos_even = LSB_FIRST_SEL ? {q.rx_cnt[1:0], 1'h0}
                             : (3'h6 - {q.rx_cnt[1:0], 1'h0});
    case (q.state)
      spi_pkg::ST_IDLE: begin
        d.sck = CLK_POL; // clock rests inactive
        d.dir = OUT_PIN_DRIVE_DIR; // direction follows while idle
        d.oe = (DIN_SELECT == `SPI_MODE_FULL) || OUT_PIN_DRIVE_DIR;
        load = q.hold_full; // only a written byte starts a transfer
      end
      spi_pkg::ST_SHIFT: begin
        if (ref_tick) begin
          d.div = (q.div == '0) ? reload : (q.div - 1'h1);
        end
        if (half_end) begin
          // master drives the clock on each underflow
          d.sck = !q.sck;
          rising = !q.sck;
          d.tog = q.tog + 5'h1;
          // sample on the chosen receive edge
          if (rising == RX_EDGE_SEL) begin
            d.rx_cnt = q.rx_cnt + 3'h1;
            if (q.dual) begin
              d.rx_sh[pos_even] = SER_OUT_PIN_I; // even bits
              d.rx_sh[pos_even | 3'h1] = SER_IN_PIN; // odd bits
            end else if (DIN_SELECT == `SPI_MODE_FULL) begin
              d.rx_sh[pos] = SER_IN_PIN; // in while out
            end else begin
              d.rx_sh[pos] = SER_OUT_PIN_I;
            end
          end
          // present the next bit on the transmit edge
          // the first bit is already out at load, so the first edge keeps it
          if ((rising == TX_EDGE_SEL) && (q.tog != '0)) begin
            d.tx_sh = LSB_FIRST_SEL ? {1'h0, q.tx_sh[7:1]}
                                    : {q.tx_sh[6:0], 1'h0};
            d.sout = LSB_FIRST_SEL ? q.tx_sh[1] : q.tx_sh[6];
          end
          if (q.tog == last_tog) begin
            d.state = spi_pkg::ST_PUSH; // byte of eight done
          end
        end
      end
      spi_pkg::ST_PUSH: begin
        if (fifo_in_ready) begin
          // next held byte starts at once, no extra clock gap
          load = q.hold_full;
          d.state = spi_pkg::ST_IDLE;
        end
      end
      default: begin
        d.state = spi_pkg::ST_IDLE;
      end
    endcase
    // take the held byte into the shifter
    if (load) begin
      d.state = spi_pkg::ST_SHIFT;
      d.tx_sh = q.hold;
      d.sout = LSB_FIRST_SEL ? q.hold[0] : q.hold[7];
      d.dir = OUT_PIN_DRIVE_DIR; // latched per byte
      d.oe = (DIN_SELECT == `SPI_MODE_FULL) || OUT_PIN_DRIVE_DIR;
      // dual read releases the output pin
      d.dual = (DIN_SELECT == `SPI_MODE_DUAL) && !OUT_PIN_DRIVE_DIR;
      d.tog = '0;
      d.rx_cnt = '0;
      d.div = reload;
      d.sck = CLK_POL;
    end
    // write marks holding full, load empties it; the write wins
    d.hold_full = (q.hold_full && !load) || TX_WR;
    if (TX_WR) begin
      d.hold = TX_WDATA;
    end
    // every shifted byte reaches the receive register
    // set wins over the host read in the same cycle
    pop = fifo_out_valid && (!q.rx_full || RX_RD);
    d.rx_full = (q.rx_full && !RX_RD) || pop;
    if (pop) begin
      d.rx_reg = fifo_out_data;
    end
    d.cs_n = !CS_ASSERT;
  end

  // ==========================================================
  // state register; reset values give empty=1, full=0
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs, all straight from state flops
  assign SER_OUT_PIN_O = q.sout;
  assign SER_OUT_PIN_OE = q.oe;
  assign SER_CLK_PIN = q.sck;
  assign CHIP_SEL_N_PIN = q.cs_n;
  assign RX_BYTE_REG = q.rx_reg;
  assign TX_HOLDING_EMPTY = !q.hold_full;
  assign RX_HOLDING_FULL = q.rx_full;
  assign TX_EMPTY_IRQ_SRC = !q.hold_full;
  assign RX_FULL_IRQ_SRC = q.rx_full;
  assign TX_DMA_REQUEST = !q.hold_full;
  assign RX_DMA_REQUEST = q.rx_full;

  // ==========================================================
  // checks
  tx_clear_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    TX_WR |=> !TX_HOLDING_EMPTY)
    else $error("holding write did not clear empty");

  load_empty_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (q.state == spi_pkg::ST_IDLE && q.hold_full && !TX_WR)
      |=> (q.state == spi_pkg::ST_SHIFT) && TX_HOLDING_EMPTY)
    else $error("held byte not taken or empty not set");

  reset_flags_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    $past(RST) |-> TX_HOLDING_EMPTY && !RX_HOLDING_FULL)
    else $error("wrong flag values after reset");

  idle_clock_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (q.state == spi_pkg::ST_IDLE && $past(q.state == spi_pkg::ST_IDLE))
      |-> SER_CLK_PIN == $past(CLK_POL))
    else $error("serial clock not at rest level");

  dir_steady_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (q.state == spi_pkg::ST_SHIFT && $past(q.state == spi_pkg::ST_SHIFT))
      |-> $stable(SER_OUT_PIN_OE))
    else $error("output direction changed mid byte");

  dual_release_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (q.state == spi_pkg::ST_SHIFT && q.dual) |-> !SER_OUT_PIN_OE)
    else $error("output pin driven during dual read");

  byte_len_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (q.state == spi_pkg::ST_SHIFT ##1 q.state == spi_pkg::ST_PUSH)
      |-> (q.tog == (q.dual ? `SPI_TOG_DUAL : `SPI_TOG_FULL))
        && (q.rx_cnt == (q.dual ? 3'h4 : 3'h0)))
    else $error("byte ended after wrong edge count");

  rx_fill_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (fifo_out_valid && !RX_HOLDING_FULL) |=> RX_HOLDING_FULL)
    else $error("received byte did not set full");

  fast_half_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (q.state == spi_pkg::ST_SHIFT && PRELOAD == '0 && $stable(PRELOAD)
      && q.tog != '0 && $past(q.state == spi_pkg::ST_SHIFT))
      |-> SER_CLK_PIN != $past(SER_CLK_PIN))
    else $error("zero preload clock not at fast rate");
endmodule

// file: inc/spi_map.svh
// Purpose: named numbers of the byte serial master
// Assumes: included by its bare name
// Notes: rates in Hz, counts in edges of the serial clock
`ifndef SPI_MAP_SVH
`define SPI_MAP_SVH
// ==========================================================
// widths and FIFO depth
`define SPI_BYTE_BITS 8
`define SPI_PRE_W 6
`define SPI_REF2M_W 6
`define SPI_FIFO_DEPTH 4
// ==========================================================
// clock rates
`define SPI_SYS_HZ 32'h05F5_E100
`define SPI_REF2M_HZ 32'h001E_8480
// ==========================================================
// serial clock toggles per byte
`define SPI_TOG_FULL 5'h10
`define SPI_TOG_DUAL 5'h08
// ==========================================================
// data-in select codes
`define SPI_MODE_FULL 2'h0
`define SPI_MODE_HALF 2'h1
`define SPI_MODE_DUAL 2'h2
`endif

// file: inc/spi_pkg.sv
// Purpose: types of the byte serial master
// Assumes: spi_map.svh on the include path
// Notes: one struct holds all state of the core except the receive FIFO
`include "spi_map.svh"
package spi_pkg;
  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SHIFT = 3'h2,
    ST_PUSH = 3'h4
  } state_e;
  // ==========================================================
  // core state
  typedef struct packed {
    state_e state;
    logic hold_full;
    logic [`SPI_BYTE_BITS-1:0] hold;
    logic [`SPI_BYTE_BITS-1:0] tx_sh;
    logic [`SPI_BYTE_BITS-1:0] rx_sh;
    logic [2:0] rx_cnt;
    logic [4:0] tog;
    logic dual;
    logic dir;
    logic oe;
    logic sck;
    logic sout;
    logic [`SPI_PRE_W-1:0] div;
    logic [`SPI_REF2M_W-1:0] pre2m;
    logic rx_full;
    logic [`SPI_BYTE_BITS-1:0] rx_reg;
    logic cs_n;
  } core_s;
endpackage

// file: dv/spi_periph_model.sv
// Purpose: behavioural serial peripheral on the far side of the master
// Assumes: it presents data on one clock edge and samples on the other
// Notes: lines it does not drive show a changing pattern, not the last bit
`timescale 1ns/1ns
module spi_periph_model (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic samp_rise,
  input wire logic [1:0] mode,
  input wire logic [7:0] reply,
  output logic miso,
  output logic io_val,
  output logic [7:0] got
);
  logic [7:0] sr = 8'h00;
  logic [7:0] rx = 8'h00;
  logic [3:0] scnt = 4'h0;
  logic [3:0] nbits;
  logic junk = 1'b0;
  // ==========================================================
  // data lines; dual puts the even bit on the shared pin
  assign nbits = (mode == 2'h2) ? 4'h4 : 4'h8;
  assign miso = (!cs_n && mode != 2'h1) ? sr[7] : junk;
  assign io_val = cs_n ? ~junk : ((mode == 2'h2) ? sr[6] : sr[7]);
  // new frame reloads the reply
  always @(negedge cs_n) begin
    sr = reply;
    scnt = 4'h0;
  end
  // ==========================================================
  // sample, then shift; the leading edge of a byte never shifts
  always @(sclk) begin
    junk = ~junk;
    if (!cs_n && sclk == samp_rise) begin
      rx = {rx[6:0], mosi};
      scnt = scnt + 4'h1;
      if (scnt == nbits) begin
        got = rx;
      end
    end else if (!cs_n && scnt == nbits) begin
      sr = reply;
      scnt = 4'h0;
    end else if (!cs_n && scnt != 4'h0) begin
      sr = (mode == 2'h2) ? {sr[5:0], 2'b00} : {sr[6:0], 1'b0};
    end
  end
endmodule

// file: dv/test_byte_spi_master.sv
// Purpose: self-checking bench for the byte serial master
// Assumes: one byte per chip-select frame in the mode table
// Notes: a loopback chain fills the receive path until the shifter stalls
`timescale 1ns/1ns
module test_byte_spi_master;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic tx_wr = 1'b0;
  logic rx_rd = 1'b0;
  logic [7:0] tx_wdata = 8'h00;
  logic [7:0] reply = 8'h00;
  logic lsb = 1'b0, tx_edge = 1'b0, rx_edge = 1'b1, pol = 1'b0, refsel = 1'b0;
  logic dir = 1'b1, cs = 1'b0, sclk_prev = 1'b0;
  logic [5:0] preload = 6'h00;
  logic [1:0] din = 2'h0;
  logic in_pin, io_val, pin_i, out_o, out_oe, sclk, cs_n, txe, rxf, txi, rxi, txd, rxd;
  logic [7:0] rx_byte, got;
  int fails = 0, comparisons = 0, tog = 0, half = 0, run = 0, base = 0;
  // ==========================================================
  // design, far-side peer and the shared data wire
  byte_spi_master dut_u (
    .CLK_SYS(clk_sys), .RST(rst), .TX_WR(tx_wr), .TX_WDATA(tx_wdata), .RX_RD(rx_rd),
    .LSB_FIRST_SEL(lsb), .TX_EDGE_SEL(tx_edge), .RX_EDGE_SEL(rx_edge), .CLK_POL(pol),
    .REF_CLOCK_SELECT(refsel), .PRELOAD(preload), .DIN_SELECT(din),
    .OUT_PIN_DRIVE_DIR(dir), .CS_ASSERT(cs), .SER_IN_PIN(in_pin), .SER_OUT_PIN_I(pin_i),
    .SER_OUT_PIN_O(out_o), .SER_OUT_PIN_OE(out_oe), .SER_CLK_PIN(sclk),
    .CHIP_SEL_N_PIN(cs_n), .RX_BYTE_REG(rx_byte), .TX_HOLDING_EMPTY(txe),
    .RX_HOLDING_FULL(rxf), .TX_EMPTY_IRQ_SRC(txi), .RX_FULL_IRQ_SRC(rxi),
    .TX_DMA_REQUEST(txd), .RX_DMA_REQUEST(rxd));
  spi_periph_model peer_u (
    .sclk(sclk), .cs_n(cs_n), .mosi(out_o), .samp_rise(rx_edge), .mode(din),
    .reply(reply), .miso(in_pin), .io_val(io_val), .got(got));
  // the master's driver wins the wire, else the peer's
  assign pin_i = out_oe ? out_o : io_val;
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // serial clock toggles and the last half period, in system cycles
  // sampled mid-cycle so the flop output is settled, not racing its edge
  always @(negedge clk_sys) begin
    sclk_prev <= sclk;
    run <= (sclk !== sclk_prev) ? 1 : run + 1;
    if (sclk !== sclk_prev) begin
      tog <= tog + 1;
      half <= run;
    end
  end
  // ==========================================================
  // compare, verdict and watchdog
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // the whole run needs well under 20000 cycles
  initial begin
    #200000;
    fails++;
    print_verdict;
  end
  // ==========================================================
  // host access: wait for empty, then one write strobe
  task automatic wr(input logic [7:0] d);
    for (int i = 0; i < 4000 && txe !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    tx_wr <= 1'b1;
    tx_wdata <= d;
    @(posedge clk_sys);
    tx_wr <= 1'b0;
    #1;
    check({7'h0, txe}, 8'h00);
  endtask
  // poll for full, compare, then one read strobe
  task automatic rd(input logic [7:0] e);
    for (int i = 0; i < 4000 && rxf !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    check({3'h0, rxf, rxi, rxd, txi ^ txe, txd ^ txe}, 8'h1C);
    check(rx_byte, e);
    @(posedge clk_sys);
    rx_rd <= 1'b1;
    @(posedge clk_sys);
    rx_rd <= 1'b0;
    #1;
  endtask
  task automatic cfg(input logic p, te, re, l, rs, input logic [5:0] pre,
                     input logic [1:0] dn, input logic dr);
    @(posedge clk_sys);
    {pol, tx_edge, rx_edge, lsb, refsel, dir} <= {p, te, re, l, rs, dr};
    preload <= pre;
    din <= dn;
    #1;
  endtask
  task automatic rst_chk;
    check({4'h0, txe, rxf, cs_n, sclk}, 8'h0A);
    check(rx_byte, 8'h00);
  endtask
  // one byte in its own frame; direction is flipped while it shifts
  task automatic xfer(input logic [7:0] d, rep, erx, input int ntog, nhalf,
                      input logic chk, input logic [7:0] egot);
    int t0;
    logic eoe;
    eoe = (din == 2'h0) || dir;
    @(posedge clk_sys);
    reply <= rep;
    cs <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    t0 = tog;
    check({7'h0, cs_n}, 8'h00);
    wr(d);
    @(posedge clk_sys);
    dir <= ~dir;
    #1;
    check({7'h0, txe}, 8'h01);
    repeat (2) @(posedge clk_sys);
    dir <= ~dir;
    #1;
    check({7'h0, out_oe}, {7'h0, eoe});
    rd(erx);
    check({7'h0, rxf}, 8'h00);
    check(8'(tog - t0), 8'(ntog));
    check(8'(half), 8'(nhalf));
    check({7'h0, sclk}, {7'h0, pol});
    if (chk) begin
      check(got, egot);
    end
    @(posedge clk_sys);
    cs <= 1'b0;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    rst_chk;
    // clock modes, bit orders, sources, half duplex both ways, dual read
    cfg(0, 0, 1, 0, 1, 6'h00, 2'h0, 1);
    xfer(8'hA5, 8'h3C, 8'h3C, 16, 1, 1, 8'hA5);
    cfg(1, 0, 1, 1, 0, 6'h02, 2'h0, 1);
    xfer(8'h83, 8'h17, 8'hE8, 16, 2, 1, 8'hC1);
    cfg(0, 1, 0, 0, 1, 6'h01, 2'h0, 1);
    xfer(8'h6E, 8'hD2, 8'hD2, 16, 50, 1, 8'h6E);
    cfg(0, 0, 1, 0, 0, 6'h03, 2'h1, 1);
    xfer(8'h4B, 8'h00, 8'h4B, 16, 3, 1, 8'h4B);
    cfg(0, 0, 1, 0, 0, 6'h01, 2'h1, 0);
    xfer(8'hFF, 8'h96, 8'h96, 16, 1, 0, 8'h00);
    cfg(0, 0, 1, 0, 0, 6'h01, 2'h2, 0);
    xfer(8'h00, 8'h5C, 8'h5C, 8, 1, 0, 8'h00);
    // loopback chain: register and fifo take five, the sixth stalls the shifter
    cfg(0, 0, 1, 0, 0, 6'h00, 2'h1, 1);
    @(posedge clk_sys);
    cs <= 1'b1;
    #1;
    base = tog;
    for (int k = 0; k < 7; k++) begin
      wr(8'h11 * 8'(k + 1));
    end
    repeat (100) @(posedge clk_sys);
    #1;
    check({7'h0, txe}, 8'h00);
    check(8'(tog - base), 8'h60);
    for (int k = 0; k < 7; k++) begin
      rd(8'h11 * 8'(k + 1));
    end
    check({7'h0, rxf}, 8'h00);
    // reset in mid-run drops an unread received byte and the receive data
    wr(8'hC3);
    repeat (40) @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    #1;
    rst_chk;
    @(posedge clk_sys);
    rst <= 1'b0;
    cs <= 1'b0;
    cfg(0, 0, 1, 0, 0, 6'h00, 2'h0, 1);
    xfer(8'h5A, 8'hC6, 8'hC6, 16, 1, 1, 8'h5A);
    print_verdict;
  end
endmodule
